// >>> design/timer8_pkg.sv
// timer8_pkg: constants shared by the 8-bit waveform timer.
// assumes nothing beyond a SystemVerilog compiler.
package timer8_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_FF = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_FF = 3'h3;
    localparam logic [2:0] WGM_RES4 = 3'h4;
    localparam logic [2:0] WGM_PC_OCA = 3'h5;
    localparam logic [2:0] WGM_RES6 = 3'h6;
    localparam logic [2:0] WGM_FAST_OCA = 3'h7;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam int WGM_BIT2 = 2;
    localparam int PRESC_DIV1 = 1;
    localparam int PRESC_DIV8 = 8;
    localparam int PRESC_DIV64 = 64;
    localparam int PRESC_DIV256 = 256;
    localparam int PRESC_DIV1024 = 1024;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_CTC, MODE_FAST, MODE_PC}
        mode_t;
endpackage

// >>> design/timer8_wave_unit.sv
// timer8_wave_unit: one compare channel, its double buffer and wave state.
// assumes count, direction and top/bottom strobes from the counter.
`timescale 1ns/1ps
`default_nettype none
module timer8_wave_unit
    import timer8_pkg::*;
#(
    parameter bit TOGGLE_OK = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic [1:0] mode_i,
    input wire logic wgm_bit2_i,
    input wire logic [1:0] action_i,
    input wire logic [7:0] cmp_buf_i,
    input wire logic [7:0] count_i,
    input wire logic [7:0] top_i,
    input wire logic down_i,
    input wire logic at_top_i,
    input wire logic at_bottom_i,
    input wire logic block_i,
    input wire logic reserved_i,
    output logic [7:0] cmp_o,
    output logic match_o,
    output logic wave_o
);
    logic load_now;
    logic is_pwm;
    logic hit;
    logic at_max;
    logic wave_next;
    logic wave_reg;
    logic [7:0] cmp_reg;

    assign is_pwm = (mode_i == MODE_FAST) || (mode_i == MODE_PC);
    // pwm compare value loads only at top (fast) or top (dual slope)
    assign load_now = !is_pwm || (tick_i && at_top_i); // [RL13]
    assign hit = (count_i == cmp_reg) && !block_i && !reserved_i; // [RL25]
    assign at_max = (cmp_reg == top_i);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_reg <= CMP_RST;
        end else if (load_now) begin
            cmp_reg <= cmp_buf_i; // [RL2] [RL13]
        end
    end

    always_comb begin
        wave_next = wave_reg;
        if (!reserved_i) begin // [RL26]
            case (mode_i)
                MODE_NORMAL, MODE_CTC: begin
                    if (hit) begin
                        case (action_i)
                            ACT_TOGGLE: wave_next = !wave_reg; // [RL4]
                            ACT_CLEAR: wave_next = 1'b0;
                            ACT_SET: wave_next = 1'b1;
                            default: wave_next = wave_reg;
                        endcase
                    end
                end
                MODE_FAST: begin
                    if (action_i == ACT_TOGGLE) begin
                        if (hit && TOGGLE_OK && wgm_bit2_i) begin
                            wave_next = !wave_reg; // [RL12]
                        end
                    end else if (action_i[1]) begin
                        // a match at top is ignored; only the top strobe drives it
                        if (at_top_i) begin
                            wave_next = !action_i[0]; // [RL10] [RL15]
                        end else if (hit) begin
                            wave_next = action_i[0]; // [RL10]
                        end
                    end
                end
                MODE_PC: begin
                    if (action_i == ACT_TOGGLE) begin
                        if (hit && TOGGLE_OK && wgm_bit2_i) begin
                            wave_next = !wave_reg; // [RL12]
                        end
                    end else if (action_i[1]) begin
                        if (at_bottom_i) begin
                            // symmetric edge at bottom without a match
                            wave_next = !action_i[0]; // [RL22]
                            if (cmp_reg == CNT_BOTTOM) begin
                                wave_next = action_i[0]; // [RL21]
                            end
                        end else if (hit && at_max) begin
                            wave_next = !action_i[0]; // [RL21]
                        end else if (hit) begin
                            wave_next = down_i ? !action_i[0]
                                               : action_i[0]; // [RL19]
                        end
                    end
                end
                default: wave_next = wave_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wave_reg <= 1'b0;
        end else if (tick_i) begin
            wave_reg <= wave_next;
        end
    end

    assign cmp_o = cmp_reg;
    assign match_o = hit;
    assign wave_o = wave_reg;
endmodule
`default_nettype wire

// >>> design/timer8_waveform_modes.sv
// timer8_waveform_modes: 8-bit timer with ctc, fast and dual-slope pwm.
// assumes control bits held steady by software logic on core_clk_i;
// pin direction bits arrive from the port block on the same clock.
// How it works
// RL1: mode 2 clears count at compare A
// RL2: ctc compare A unbuffered; late write wraps
// RL3: ctc sets compare A flag at top
// RL4: ctc action 1 toggles wave A
// RL5: toggle frequency clk/(2N(1+compare))
// RL6: pin driven only when direction is output
// RL7: ctc overflow flag on MAX to zero
// RL8: modes 3,7 fast pwm, top FF or A
// RL9: fast pwm clears count after top
// RL10: action 2 clear/set, 3 set/clear
// RL11: fast pwm overflow flag at top
// RL12: pwm toggle only A with bit2 set
// RL13: pwm compare values double buffered
// RL14: prescale 1,8,64,256,1024; 256-clock period
// RL15: fast extremes: spike or constant level
// RL16: modes 1,5 dual slope, top FF or A
// RL17: dual slope reverses, holds top once
// RL18: dual slope overflow flag at bottom
// RL19: dual slope up clears, down sets
// RL20: dual slope period 510 clocks
// RL21: dual slope extremes hold constant level
// RL22: dual slope bottom edge keeps symmetry
// RL23: mode 0 counts up and wraps
// RL24: compare flag next tick, one clears
// RL25: count write blocks next match
// RL26: modes 4,6 count normally, no outputs
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_modes
    import timer8_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] clock_select_i,
    input wire logic [2:0] waveform_select_field_i,
    input wire logic [1:0] output_action_a_i,
    input wire logic [1:0] output_action_b_i,
    input wire logic [7:0] compare_value_a_i,
    input wire logic [7:0] compare_value_b_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wr_data_i,
    input wire logic flag_clr_ovf_i,
    input wire logic flag_clr_a_i,
    input wire logic flag_clr_b_i,
    input wire logic dir_out_a_i,
    input wire logic dir_out_b_i,
    output logic [7:0] timer_count_value_o,
    output logic overflow_flag_o,
    output logic compare_a_flag_o,
    output logic compare_b_flag_o,
    output logic wave_out_a_o,
    output logic wave_out_a_oe_o,
    output logic wave_out_b_o,
    output logic wave_out_b_oe_o
);
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic rst_n;
    logic [9:0] presc_reg;
    logic tick;
    logic tick_reg;
    mode_t mode;
    logic reserved;
    logic [7:0] top;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic down_reg;
    logic down_next;
    logic at_top;
    logic at_bottom;
    logic block_reg;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic match_a;
    logic match_b;
    logic wave_a;
    logic wave_b;
    logic ovf_set;
    logic ovf_reg;
    logic cfa_reg;
    logic cfb_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // prescaler: one-cycle enable every N core clocks
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 10'h000;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    always_comb begin
        case (clock_select_i)
            CS_DIV1: tick = 1'b1; // [RL14]
            CS_DIV8: tick = presc_reg[2:0] == 3'h7;
            CS_DIV64: tick = presc_reg[5:0] == 6'h3F;
            CS_DIV256: tick = presc_reg[7:0] == 8'hFF;
            CS_DIV1024: tick = presc_reg == 10'h3FF;
            default: tick = 1'b0;
        endcase
    end

    always_comb begin
        reserved = 1'b0;
        case (waveform_select_field_i)
            WGM_CTC: mode = MODE_CTC;
            WGM_FAST_FF, WGM_FAST_OCA: mode = MODE_FAST; // [RL8]
            WGM_PC_FF, WGM_PC_OCA: mode = MODE_PC; // [RL16]
            WGM_RES4, WGM_RES6: begin
                mode = MODE_NORMAL; // [RL26]
                reserved = 1'b1;
            end
            default: mode = MODE_NORMAL; // [RL23]
        endcase
    end

    // in ctc the unbuffered compare value is top [RL1]
    assign top = (waveform_select_field_i[WGM_BIT2] ||
                  mode == MODE_CTC) ? cmp_a : CNT_MAX;
    assign at_top = (count_reg == top);
    assign at_bottom = (count_reg == CNT_BOTTOM);

    always_comb begin
        count_next = count_reg + 8'h01;
        down_next = down_reg;
        case (mode)
            MODE_CTC: begin
                // a top below the count is missed until wrap [RL2]
                // the clear is a compare match, so a count write skips it
                if (at_top && !block_reg) begin
                    count_next = CNT_BOTTOM; // [RL1] [RL5] [RL25]
                end
            end
            MODE_FAST: begin
                if (at_top) begin
                    count_next = CNT_BOTTOM; // [RL9]
                end
            end
            MODE_PC: begin
                // top and bottom each held one tick: 510 per period
                if (!down_reg && at_top) begin
                    down_next = 1'b1; // [RL17] [RL20]
                    count_next = count_reg - 8'h01;
                end else if (down_reg && at_bottom) begin
                    down_next = 1'b0;
                    count_next = count_reg + 8'h01;
                end else if (down_reg) begin
                    count_next = count_reg - 8'h01;
                end
                if (top == CNT_BOTTOM) begin
                    count_next = CNT_BOTTOM;
                end
            end
            default: count_next = count_reg + 8'h01; // [RL23]
        endcase
        if (mode != MODE_PC) begin
            down_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= CNT_RST;
            down_reg <= 1'b0;
        end else if (count_wr_i) begin
            count_reg <= count_wr_data_i;
        end else if (tick) begin
            count_reg <= count_next;
            down_reg <= down_next;
        end
    end

    // block lasts until the next timer tick has passed
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            block_reg <= 1'b0;
        end else if (count_wr_i) begin
            block_reg <= 1'b1; // [RL25]
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    timer8_wave_unit #(
        .TOGGLE_OK(1'b1)
    ) u_wave_a (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .tick_i(tick),
        .mode_i(mode),
        .wgm_bit2_i(waveform_select_field_i[WGM_BIT2]),
        .action_i(output_action_a_i),
        .cmp_buf_i(compare_value_a_i),
        .count_i(count_reg),
        .top_i(top),
        .down_i(down_reg),
        .at_top_i(at_top),
        .at_bottom_i(at_bottom),
        .block_i(block_reg),
        .reserved_i(reserved),
        .cmp_o(cmp_a),
        .match_o(match_a),
        .wave_o(wave_a)
    );

    timer8_wave_unit #(
        .TOGGLE_OK(1'b0)
    ) u_wave_b (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .tick_i(tick),
        .mode_i(mode),
        .wgm_bit2_i(waveform_select_field_i[WGM_BIT2]),
        .action_i(output_action_b_i),
        .cmp_buf_i(compare_value_b_i),
        .count_i(count_reg),
        .top_i(top),
        .down_i(down_reg),
        .at_top_i(at_top),
        .at_bottom_i(at_bottom),
        .block_i(block_reg),
        .reserved_i(reserved),
        .cmp_o(cmp_b),
        .match_o(match_b),
        .wave_o(wave_b)
    );

    always_comb begin
        case (mode)
            MODE_FAST: ovf_set = at_top; // [RL11]
            MODE_PC: ovf_set = at_bottom && down_reg; // [RL18]
            default: ovf_set = (count_reg == CNT_MAX) &&
                               (count_next == CNT_BOTTOM); // [RL7]
        endcase
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
            cfa_reg <= 1'b0;
            cfb_reg <= 1'b0;
        end else begin
            ovf_reg <= (tick && ovf_set) ||
                       (ovf_reg && !flag_clr_ovf_i);
            cfa_reg <= (tick && match_a) ||
                       (cfa_reg && !flag_clr_a_i); // [RL3] [RL24]
            cfb_reg <= (tick && match_b) ||
                       (cfb_reg && !flag_clr_b_i); // [RL24]
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= 1'b0;
            timer_count_value_o <= CNT_RST;
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
            wave_out_a_oe_o <= 1'b0;
            wave_out_b_oe_o <= 1'b0;
        end else begin
            tick_reg <= tick;
            timer_count_value_o <= count_reg;
            wave_out_a_o <= wave_a;
            wave_out_b_o <= wave_b;
            wave_out_a_oe_o <= dir_out_a_i &&
                               (output_action_a_i != ACT_NONE); // [RL6]
            wave_out_b_oe_o <= dir_out_b_i &&
                               (output_action_b_i != ACT_NONE); // [RL6]
        end
    end
    assign overflow_flag_o = ovf_reg;
    assign compare_a_flag_o = cfa_reg;
    assign compare_b_flag_o = cfb_reg;

    a_ctc_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && mode == MODE_CTC && count_reg == cmp_a && !count_wr_i
         && !block_reg)
        |=> count_reg == CNT_BOTTOM) else $error("ctc did not clear"); // [RL1]
    a_cfa_set: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && match_a) |=> cfa_reg) else $error("flag a not set"); // [RL3]
    a_fast_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && mode == MODE_FAST && at_top && !count_wr_i)
        |=> count_reg == CNT_BOTTOM) else $error("fast no wrap"); // [RL9]
    a_fast_ovf: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && mode == MODE_FAST && at_top) |=> ovf_reg)
        else $error("fast ovf missing"); // [RL11]
    a_pc_ovf: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && mode == MODE_PC && at_bottom && down_reg) |=> ovf_reg)
        else $error("pc ovf missing"); // [RL18]
    a_pc_turn: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        (tick && mode == MODE_PC && !down_reg && at_top && !count_wr_i
         && top != CNT_BOTTOM) |=> down_reg) else $error("no turn"); // [RL17]
    a_write_block: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        count_wr_i |=> !match_a && !match_b) else $error("unblocked"); // [RL25]
    a_oe_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        !dir_out_a_i |=> !wave_out_a_oe_o) else $error("oe leak"); // [RL6]
endmodule
`default_nettype wire

// >>> verification/pin_load.sv
// pin_load: one port pin with a weak pull-up, fed by a wave output.
// assumes wave and drive enable come straight from the timer outputs.
`timescale 1ns/1ps
`default_nettype none
module pin_load (
    input wire logic wave_i,
    input wire logic oe_i,
    output logic pin_o
);
    // a released pin goes to the pull-up, never the last wave value
    assign pin_o = oe_i ? wave_i : 1'b1;
endmodule
`default_nettype wire

// >>> verification/tb.sv
// tb: self-checking bench for the 8-bit waveform timer, one task a mode, two for ctc.
// assumes the timer package and pin_load; prescale /1 unless stated.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import timer8_pkg::*;
    logic clk, rst_n, cnt_wr, clr_ovf, clr_a, clr_b, dir_a, dir_b;
    logic [2:0] cs, wgm;
    logic [1:0] act_a, act_b;
    logic [7:0] cmp_a, cmp_b, wr_data, count, m;
    logic ovf, flag_a, flag_b, wave_a, oe_a, wave_b, oe_b, pin_a, pin_b;
    int n_errors = 0;
    int comparisons = 0;
    int p, h;

    timer8_waveform_modes i_timer8_waveform_modes (
        .core_clk_i(clk),
        .rst_n_i(rst_n),
        .clock_select_i(cs),
        .waveform_select_field_i(wgm),
        .output_action_a_i(act_a),
        .output_action_b_i(act_b),
        .compare_value_a_i(cmp_a),
        .compare_value_b_i(cmp_b),
        .count_wr_i(cnt_wr),
        .count_wr_data_i(wr_data),
        .flag_clr_ovf_i(clr_ovf),
        .flag_clr_a_i(clr_a),
        .flag_clr_b_i(clr_b),
        .dir_out_a_i(dir_a),
        .dir_out_b_i(dir_b),
        .timer_count_value_o(count),
        .overflow_flag_o(ovf),
        .compare_a_flag_o(flag_a),
        .compare_b_flag_o(flag_b),
        .wave_out_a_o(wave_a),
        .wave_out_a_oe_o(oe_a),
        .wave_out_b_o(wave_b),
        .wave_out_b_oe_o(oe_b)
    );
    pin_load i_pin_a (.wave_i(wave_a), .oe_i(oe_a), .pin_o(pin_a));
    pin_load i_pin_b (.wave_i(wave_b), .oe_i(oe_b), .pin_o(pin_b));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cfg(input logic [2:0] c, w, input logic [1:0] a, b,
                       input logic [7:0] ca, cb);
        @(negedge clk);
        {cs, wgm, act_a, act_b} = {c, w, a, b};
        {cmp_a, cmp_b} = {ca, cb};
    endtask

    task automatic clr(input logic [2:0] f);
        @(negedge clk);
        {clr_ovf, clr_a, clr_b} = f;
        @(negedge clk);
        {clr_ovf, clr_a, clr_b} = 3'h0;
    endtask

    function automatic logic wv(input bit b);
        return b ? wave_b : wave_a;
    endfunction

    task automatic hi_cnt(input bit b, input int n);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            if (wv(b) === 1'b1) h++;
        end
    endtask

    task automatic max_cnt(input int n);
        m = 8'h00;
        repeat (n) begin
            @(negedge clk);
            if (count > m) m = count;
        end
    endtask

    task automatic wait_cnt(input logic [7:0] v);
        int k;
        k = 0;
        while (count !== v && k < 3000) begin
            @(negedge clk);
            k++;
        end
    endtask

    // bounded search so that a stuck output fails instead of hanging
    task automatic rise(input bit b, output int k);
        logic prev;
        k = 0;
        do begin
            prev = wv(b);
            @(negedge clk);
            k++;
        end while (!(prev === 1'b0 && wv(b) === 1'b1) && k < 5000);
    endtask

    task automatic period(input bit b);
        int k;
        rise(b, k);
        rise(b, p);
    endtask

    task automatic t_ctc;
        cfg(3'h1, WGM_CTC, ACT_TOGGLE, ACT_NONE, 8'h02, 8'h00);
        dir_a = 1'b1;
        max_cnt(64);
        chk(m === 8'h02, "ctc top");
        chk(flag_a === 1'b1, "ctc flag a");
        period(0);
        chk(p == 6, "ctc toggle period");
        chk(pin_a === wave_a && oe_a === 1'b1, "pin follows wave");
        chk(oe_b === 1'b0 && pin_b === 1'b1, "b idle not driven");
        cfg(3'h1, WGM_CTC, ACT_TOGGLE, ACT_NONE, 8'h00, 8'h00);
        dir_a = 1'b0;
        period(0);
        chk(p == 2, "ctc fastest toggle");
        chk(oe_a === 1'b0 && pin_a === 1'b1, "pin released");
    endtask

    task automatic t_late;
        cfg(3'h1, WGM_CTC, ACT_NONE, ACT_NONE, 8'hC8, 8'h00);
        wait_cnt(8'h64);
        cmp_a = 8'h32;
        clr(3'b100);
        max_cnt(300);
        chk(m === CNT_MAX, "late compare wraps");
        chk(ovf === 1'b1, "ctc overflow at wrap");
        clr(3'b100);
        max_cnt(200);
        chk(m === 8'h32, "new top after wrap");
        chk(ovf === 1'b0, "no overflow below max");
        cfg(3'h0, WGM_CTC, ACT_NONE, ACT_NONE, 8'h32, 8'h00);
        @(negedge clk);
        {cnt_wr, wr_data} = {1'b1, 8'h32};
        @(negedge clk);
        {cnt_wr, cs} = {1'b0, 3'h1};
        max_cnt(300);
        chk(m === CNT_MAX, "count write blocks match");
    endtask

    task automatic t_normal;
        cfg(3'h1, WGM_NORMAL, ACT_NONE, ACT_NONE, 8'h00, 8'h80);
        max_cnt(300);
        chk(m === CNT_MAX, "normal wraps");
        wait_cnt(8'h10);
        clr(3'b001);
        chk(flag_b === 1'b0, "flag b cleared");
        idle(120);
        chk(flag_b === 1'b1, "flag b set on match");
        for (int i = 4; i < 7; i += 2) begin
            cfg(3'h1, 3'(i), ACT_CLEAR, ACT_SET, 8'h40, 8'h40);
            hi_cnt(0, 300);
            chk(h == 0 || h == 300, "reserved mode moved wave");
            max_cnt(300);
            chk(m === CNT_MAX, "reserved mode counts");
        end
    endtask

    task automatic t_fast;
        cfg(3'h1, WGM_FAST_FF, ACT_CLEAR, ACT_SET, 8'h40, 8'h40);
        idle(600);
        period(0);
        chk(p == 256, "fast period");
        hi_cnt(0, 256);
        chk(h == 65, "fast non-inverting duty");
        hi_cnt(1, 256);
        chk(h == 191, "fast inverting duty");
        wait_cnt(8'h10);
        clr(3'b100);
        idle(16);
        chk(ovf === 1'b0, "no overflow mid period");
        idle(250);
        chk(ovf === 1'b1, "overflow at top");
        wait_cnt(8'h30);
        cmp_a = 8'h60;
        wait_cnt(8'h50);
        chk(wave_a === 1'b0, "old compare still used");
        idle(300);
        hi_cnt(0, 256);
        chk(h == 97, "new compare after top");
        cmp_a = 8'h00;
        idle(600);
        hi_cnt(0, 256);
        chk(h == 1, "spike at bottom");
        cmp_a = CNT_MAX;
        idle(600);
        hi_cnt(0, 256);
        chk(h == 256, "constant at max");
        act_a = ACT_TOGGLE;
        hi_cnt(0, 300);
        chk(h == 300, "no toggle without bit2");
        cfg(3'h1, WGM_FAST_OCA, ACT_TOGGLE, ACT_TOGGLE, 8'h09, 8'h04);
        idle(600);
        max_cnt(64);
        chk(m === 8'h09, "top from compare a");
        period(0);
        chk(p == 20, "toggle with bit2");
        hi_cnt(1, 64);
        chk(h == 0 || h == 64, "no toggle on b");
        cfg(3'h2, WGM_FAST_FF, ACT_CLEAR, ACT_NONE, 8'h40, 8'h00);
        period(0);
        chk(p == 2048, "period at prescale 8");
    endtask

    task automatic t_pc;
        int k;
        cfg(3'h1, WGM_PC_FF, ACT_CLEAR, ACT_SET, 8'h00, 8'h00);
        idle(1100);
        hi_cnt(0, 510);
        chk(h == 0, "bottom compare low");
        cmp_a = CNT_MAX;
        idle(1100);
        hi_cnt(0, 510);
        chk(h == 510, "max compare high");
        {cmp_a, cmp_b} = {8'h40, 8'h40};
        idle(1100);
        period(0);
        chk(p == 510, "dual slope period");
        hi_cnt(0, 510);
        chk(h >= 126 && h <= 130, "dual slope duty");
        {k, h} = 0;
        repeat (510) begin
            @(negedge clk);
            if (wave_b !== ~wave_a) k++;
            if (count === CNT_MAX) h++;
        end
        chk(k == 0, "inverting is complement");
        chk(h == 1, "top held one cycle");
        wait_cnt(8'h80);
        clr(3'b100);
        idle(100);
        chk(ovf === 1'b0, "no overflow near top");
        idle(300);
        chk(ovf === 1'b1, "overflow at bottom");
        cfg(3'h1, WGM_PC_OCA, ACT_NONE, ACT_CLEAR, 8'h14, 8'h0A);
        idle(1100);
        max_cnt(100);
        chk(m === 8'h14, "dual slope top from a");
        period(1);
        chk(p == 40, "dual slope short period");
        chk(oe_b === 1'b1 && pin_b === wave_b, "pin b driven");
    endtask

    initial begin
        rst_n = 1'b0;
        {cnt_wr, clr_ovf, clr_a, clr_b, dir_a, dir_b} = 6'h00;
        {cs, wgm, act_a, act_b} = 10'h000;
        {cmp_a, cmp_b, wr_data} = 24'h00_0000;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        dir_b = 1'b1;
        idle(4);
        t_ctc();
        t_late();
        t_normal();
        t_fast();
        t_pc();
        end_of_test();
    end

    // about 20k cycles are expected; the limit is 50k cycles
    initial begin
        #200_000;
        n_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
